// [l1c_cache.v]
`timescale 1ns/1ps
`include "l1c_map.vh"
// Notes on behaviour
// - lines hold four 32-bit words, one tag, filled whole from memory
// - instruction cache 2 KB, data cache 1 KB
// - instruction tag: 22-bit physical tag, valid, parity = 24 bits
// - instruction data: one parity bit per word
// - direct mapped, virtual index, physical tag compare
// - data tag: 22-bit tag, valid, parity, written, written parity = 26 bits
// - data cache index is VA[9:4]
// - instruction cache index is VA[10:4]
// - hits return data; misses fetch the line from memory
// - data cache is write-back, stores go into the line
// - dirty line written back only on replacement or write-back op
// - a written-back line becomes invalid
// - data lines are invalid, valid clean or valid dirty
// - instruction lines invalid or valid; invalid never hits
// - fills and first store change state; reads and dirty stores do not
// - tag and data parity checked on every cache read
// - parity error raises cache error; source recorded in error register except in a cycle that answers a control register access
// - write-back checks parity, passes data parity, makes address byte parity
// - write-back data parity error still writes data, raises error
// - write-back tag parity error issues no bus write, raises error
// - tag parity error in maintenance op raises error and aborts it
// - parity exception disable suppresses the exception
// - single cycle read hits, one store per cycle
module l1c_cache #(
	parameter IC_SETS = `L1C_IC_SETS,
	parameter DC_SETS = `L1C_DC_SETS
) (
	input wire clk_in,
	input wire sys_rst_in,
	input wire clk_en_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [7:0] paddr_in,
	input wire [31:0] pwdata_in,
	output reg [31:0] prdata_out,
	output reg pready_out,
	output reg pslverr_out,
	input wire if_req_in,
	input wire [31:0] if_va_in,
	input wire [31:0] if_pa_in,
	output reg if_valid_out,
	output reg [31:0] if_data_out,
	input wire ls_req_in,
	input wire ls_wr_in,
	input wire [31:0] ls_va_in,
	input wire [31:0] ls_pa_in,
	input wire [31:0] ls_wdata_in,
	input wire [3:0] ls_be_in,
	output reg ls_valid_out,
	output reg [31:0] ls_rdata_out,
	input wire op_req_in,
	input wire [1:0] op_code_in,
	input wire [31:0] op_va_in,
	input wire [31:0] op_pa_in,
	output reg op_done_out,
	output reg mem_rd_out,
	output reg [31:0] mem_addr_out,
	input wire mem_rvalid_in,
	input wire [31:0] mem_rdata_in,
	input wire mem_rpar_in,
	output reg wb_valid_out,
	output reg [31:0] wb_addr_out,
	output reg [3:0] wb_addr_par_out,
	output reg [31:0] wb_data_out,
	output reg wb_data_par_out,
	input wire wb_ready_in,
	output reg cache_err_exc_out
);
	localparam S_IDLE = 6'h01;
	localparam S_WB = 6'h02;
	localparam S_FILL = 6'h04;
	localparam S_DONE = 6'h08;
	localparam S_OPWB = 6'h10;
	localparam S_HOLD = 6'h20;
	localparam OP_INV = 2'h0;
	localparam OP_WB = 2'h1;
	localparam OP_WBINV = 2'h2;

	// even parity helper, used for data, tag and address bytes
	function par;
		input [31:0] v;
		begin
			par = ^v;
		end
	endfunction

	// tag parity covers valid and tag; the written flag has its own bit
	function tag_par;
		input [22:0] t;
		begin
			tag_par = par({9'h000, t});
		end
	endfunction

	// arrays sized from set counts; line = 4 words + 4 parity bits
	reg [23:0] ic_tag [0:IC_SETS-1];
	reg [32:0] ic_dat [0:IC_SETS*4-1];
	reg [25:0] dc_tag [0:DC_SETS-1];
	reg [32:0] dc_dat [0:DC_SETS*4-1];
	reg [1:0] ctrl;
	reg [`L1C_ERR_W-1:0] err;
	reg [5:0] state;
	reg is_dc;
	reg is_op;
	reg [31:0] pa;
	reg [6:0] idx;
	reg [1:0] cnt;
	reg st_pend;
	reg [31:0] st_data;
	reg [3:0] st_be;
	reg [1:0] st_word;
	reg [`L1C_ERR_W-1:0] next_err;
	integer i;

	wire [6:0] ic_idx = if_va_in[10:4];
	wire [5:0] dc_idx = ls_va_in[9:4];
	wire [5:0] op_idx = op_va_in[9:4];
	wire [23:0] ic_t = ic_tag[ic_idx];
	wire [32:0] ic_w = ic_dat[{ic_idx, if_va_in[3:2]}];
	wire [25:0] dc_t = dc_tag[dc_idx];
	wire [32:0] dc_w = dc_dat[{dc_idx, ls_va_in[3:2]}];
	wire [25:0] op_t = dc_tag[op_idx];
	// valid is bit 22; invalid lines never hit
	wire ic_tperr = tag_par(ic_t[22:0]) != ic_t[23];
	wire ic_hit = ic_t[22] && ic_t[21:0] == if_pa_in[31:10];
	wire ic_dperr = par(ic_w[31:0]) != ic_w[32];
	wire dc_tperr = tag_par(dc_t[22:0]) != dc_t[23] || dc_t[25] != dc_t[24];
	wire dc_dirty = dc_t[24];
	wire dc_hit = dc_t[22] && dc_t[21:0] == ls_pa_in[31:10];
	wire dc_dperr = par(dc_w[31:0]) != dc_w[32];
	wire op_tperr = tag_par(op_t[22:0]) != op_t[23];
	// write-back ops write back only the line that holds the given physical address; write-back-invalidate also drops the indexed line on a miss
	wire op_hit = op_t[22] && op_t[21:0] == op_pa_in[31:10];
	wire idle = state == S_IDLE;
	wire ic_go = idle && if_req_in;
	wire dc_go = idle && !if_req_in && ls_req_in;
	wire op_go = idle && !if_req_in && !ls_req_in && op_req_in;
	wire [31:0] mrg = {ls_be_in[3] ? ls_wdata_in[31:24] : dc_w[31:24],
		ls_be_in[2] ? ls_wdata_in[23:16] : dc_w[23:16],
		ls_be_in[1] ? ls_wdata_in[15:8] : dc_w[15:8],
		ls_be_in[0] ? ls_wdata_in[7:0] : dc_w[7:0]};
	wire [25:0] vic = dc_tag[idx[5:0]];
	wire [32:0] vic_w = dc_dat[{idx[5:0], cnt}];
	wire vic_tperr = tag_par(vic[22:0]) != vic[23];
	wire [31:0] vic_pa = {vic[21:0], idx[5:0], cnt, 2'h0};
	wire apb_acc = psel_in && penable_in && !pready_out;

	// error sources collected for this cycle
	always @* begin
		next_err = {`L1C_ERR_W{1'b0}};
		next_err[`L1C_ERR_IC_TAG] = ic_go && ic_tperr;
		next_err[`L1C_ERR_IC_DATA] = ic_go && ic_hit && !ic_tperr && ic_dperr;
		next_err[`L1C_ERR_DC_TAG] = dc_go && dc_tperr;
		next_err[`L1C_ERR_DC_DATA] = dc_go && !ls_wr_in && dc_hit && !dc_tperr && dc_dperr;
		next_err[`L1C_ERR_MEM] = state == S_FILL && mem_rvalid_in &&
			par(mem_rdata_in) != mem_rpar_in;
		next_err[`L1C_ERR_WB_TAG] = (state == S_WB || state == S_OPWB) && cnt == 2'h0 &&
			!wb_valid_out && vic_tperr;
		next_err[`L1C_ERR_WB_DATA] = (state == S_WB || state == S_OPWB) && !wb_valid_out &&
			!vic_tperr && par(vic_w[31:0]) != vic_w[32];
		next_err[`L1C_ERR_OP_TAG] = op_go && op_tperr;
	end

	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			ctrl <= `L1C_CTRL_RST;
			err <= {`L1C_ERR_W{1'b0}};
			state <= S_IDLE;
			is_dc <= 1'b0;
			is_op <= 1'b0;
			pa <= 32'h00000000;
			idx <= 7'h00;
			cnt <= 2'h0;
			st_pend <= 1'b0;
			st_data <= 32'h00000000;
			st_be <= 4'h0;
			st_word <= 2'h0;
			prdata_out <= 32'h00000000;
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			if_valid_out <= 1'b0;
			if_data_out <= 32'h00000000;
			ls_valid_out <= 1'b0;
			ls_rdata_out <= 32'h00000000;
			op_done_out <= 1'b0;
			mem_rd_out <= 1'b0;
			mem_addr_out <= 32'h00000000;
			wb_valid_out <= 1'b0;
			wb_addr_out <= 32'h00000000;
			wb_addr_par_out <= 4'h0;
			wb_data_out <= 32'h00000000;
			wb_data_par_out <= 1'b0;
			cache_err_exc_out <= 1'b0;
		end else if (clk_en_in) begin
			if_valid_out <= 1'b0;
			ls_valid_out <= 1'b0;
			op_done_out <= 1'b0;
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			// sticky source bits; a new error wins over a software clear
			cache_err_exc_out <= |next_err && !ctrl[`L1C_CTRL_PXD_BIT];
			if (apb_acc) begin
				pready_out <= 1'b1;
				prdata_out <= 32'h00000000;
				case (paddr_in)
				`L1C_APB_CTRL: begin
					prdata_out <= {30'h00000000, ctrl};
					if (pwrite_in)
						ctrl <= pwdata_in[1:0];
				end
				`L1C_APB_ERR: begin
					prdata_out <= {24'h000000, err};
					if (pwrite_in)
						err <= (err & ~pwdata_in[`L1C_ERR_W-1:0]) | next_err;
					else
						err <= err | next_err;
				end
				`L1C_APB_STAT: begin
					prdata_out <= {26'h0000000, state};
					err <= err | next_err;
				end
				default: begin
					pslverr_out <= 1'b1;
					err <= err | next_err;
				end
				endcase
			end else
				err <= err | next_err;
			// the second stage of a pipelined store writes the data RAM
			if (st_pend) begin
				dc_dat[{idx[5:0], st_word}] <= {par(st_data), st_data};
				st_pend <= 1'b0;
			end
			if (ctrl[`L1C_CTRL_INV_BIT] && idle) begin
				// software flush: drop every tag without write-back, intended for boot only
				for (i = 0; i < IC_SETS; i = i + 1)
					ic_tag[i] <= 24'h000000;
				for (i = 0; i < DC_SETS; i = i + 1)
					dc_tag[i] <= 26'h0000000;
				ctrl[`L1C_CTRL_INV_BIT] <= 1'b0;
			end else begin
				case (state)
				S_IDLE: begin
					// a request still high after its answer is served again, harmlessly
					if (if_req_in) begin
						is_dc <= 1'b0;
						pa <= if_pa_in;
						idx <= ic_idx;
						if (ic_hit && !ic_tperr) begin
							if_valid_out <= 1'b1;
							if_data_out <= ic_w[31:0];
						end else if (!ic_tperr) begin
							cnt <= 2'h0;
							mem_rd_out <= 1'b1;
							mem_addr_out <= {if_pa_in[31:4], 4'h0};
							state <= S_FILL;
						end
					end else if (ls_req_in) begin
						is_dc <= 1'b1;
						is_op <= 1'b0;
						pa <= ls_pa_in;
						idx <= {1'b0, dc_idx};
						cnt <= 2'h0;
						if (dc_tperr) begin
							ls_valid_out <= 1'b0;
						end else if (dc_hit) begin
							ls_valid_out <= 1'b1;
							ls_rdata_out <= dc_w[31:0];
							if (ls_wr_in) begin
								st_pend <= 1'b1;
								st_data <= mrg;
								st_word <= ls_va_in[3:2];
								if (!dc_dirty)
									// written flag and its even parity bit are both one
									dc_tag[dc_idx] <= {2'h3, dc_t[23:0]};
							end
						end else if (dc_t[22] && dc_dirty) begin
							state <= S_WB;
						end else begin
							mem_rd_out <= 1'b1;
							mem_addr_out <= {ls_pa_in[31:4], 4'h0};
							state <= S_FILL;
						end
						st_be <= ls_be_in;
					end else if (op_req_in) begin
						is_op <= 1'b1;
						idx <= {1'b0, op_idx};
						cnt <= 2'h0;
						if (op_tperr) begin
							op_done_out <= 1'b1;
						end else if (op_code_in == OP_INV) begin
							dc_tag[op_idx] <= 26'h0000000;
							op_done_out <= 1'b1;
						end else if (op_hit && op_t[24] &&
							(op_code_in == OP_WB || op_code_in == OP_WBINV)) begin
							state <= S_OPWB;
						end else begin
							if (op_code_in == OP_WBINV)
								dc_tag[op_idx] <= 26'h0000000;
							op_done_out <= 1'b1;
						end
					end
				end
				S_WB, S_OPWB: begin
					if (!wb_valid_out) begin
						if (vic_tperr && cnt == 2'h0) begin
							// bus write suppressed; stall then return idle
							state <= S_HOLD;
						end else begin
							wb_valid_out <= 1'b1;
							wb_addr_out <= vic_pa;
							wb_addr_par_out <= {par({24'h000000, vic_pa[31:24]}),
								par({24'h000000, vic_pa[23:16]}),
								par({24'h000000, vic_pa[15:8]}),
								par({24'h000000, vic_pa[7:0]})};
							wb_data_out <= vic_w[31:0];
							wb_data_par_out <= vic_w[32];
						end
					end else if (wb_ready_in) begin
						wb_valid_out <= 1'b0;
						cnt <= cnt + 2'h1;
						if (cnt == 2'h3) begin
							dc_tag[idx[5:0]] <= 26'h0000000;
							if (state == S_OPWB) begin
								op_done_out <= 1'b1;
								state <= S_IDLE;
							end else begin
								mem_rd_out <= 1'b1;
								mem_addr_out <= {pa[31:4], 4'h0};
								state <= S_FILL;
							end
						end
					end
				end
				S_FILL: begin
					if (mem_rvalid_in) begin
						if (is_dc)
							dc_dat[{idx[5:0], cnt}] <= {mem_rpar_in, mem_rdata_in};
						else
							ic_dat[{idx, cnt}] <= {mem_rpar_in, mem_rdata_in};
						cnt <= cnt + 2'h1;
						mem_addr_out <= {pa[31:4], cnt + 2'h1, 2'h0};
						if (cnt == 2'h3) begin
							mem_rd_out <= 1'b0;
							if (is_dc)
								dc_tag[idx[5:0]] <= {2'h0, par({9'h000, 1'b1, pa[31:10]}),
									1'b1, pa[31:10]};
							else
								ic_tag[idx] <= {par({9'h000, 1'b1, pa[31:10]}), 1'b1,
									pa[31:10]};
							state <= S_DONE;
						end
					end
				end
				S_DONE, S_HOLD: begin
					// after a fill the requester retries and now hits; after S_HOLD the line is left unchanged
					state <= S_IDLE;
				end
				default: state <= S_IDLE;
				endcase
			end
		end
	end
endmodule

// [l1c_cache_props.sv]
`timescale 1ns/1ps
`include "l1c_map.vh"
module l1c_cache_props (
	input wire clk_in,
	input wire sys_rst_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [7:0] paddr_in,
	input wire [31:0] pwdata_in,
	input wire pready_out,
	input wire if_req_in,
	input wire if_valid_out,
	input wire ls_req_in,
	input wire ls_valid_out,
	input wire mem_rd_out,
	input wire mem_rvalid_in,
	input wire wb_valid_out,
	input wire [31:0] wb_addr_out,
	input wire [3:0] wb_addr_par_out,
	input wire [31:0] wb_data_out,
	input wire wb_ready_in,
	input wire cache_err_exc_out
);
	reg pxd;
	reg [2:0] beats;
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	// shadow of the exception disable bit, tracked from completed writes
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			pxd <= 1'b1;
			beats <= 3'h0;
		end else begin
			if (psel_in && penable_in && pwrite_in && pready_out && paddr_in == `L1C_APB_CTRL)
				pxd <= pwdata_in[`L1C_CTRL_PXD_BIT];
			if (!mem_rd_out)
				beats <= 3'h0;
			else if (mem_rvalid_in)
				beats <= beats + 3'h1;
		end
	end
	addr_parity_a: assert property (wb_valid_out |-> wb_addr_par_out ==
		{^wb_addr_out[31:24], ^wb_addr_out[23:16], ^wb_addr_out[15:8], ^wb_addr_out[7:0]})
		else $error("write-back address parity wrong");
	wb_hold_a: assert property (wb_valid_out && !wb_ready_in |=> wb_valid_out &&
		$stable(wb_addr_out) && $stable(wb_data_out)) else $error("write-back word dropped");
	wb_before_fill_a: assert property (wb_valid_out |-> !mem_rd_out)
		else $error("fill overlaps write-back");
	fetch_answer_a: assert property (if_valid_out |-> $past(if_req_in))
		else $error("fetch answer without request");
	load_answer_a: assert property (ls_valid_out |-> $past(ls_req_in))
		else $error("load answer without request");
	fill_beats_a: assert property (mem_rd_out |-> beats <= 3'h3)
		else $error("fill longer than a line");
	fill_end_a: assert property ($fell(mem_rd_out) |-> $past(beats) == 3'h3 &&
		$past(mem_rvalid_in)) else $error("fill ended early");
	exc_disable_a: assert property (cache_err_exc_out |-> !pxd)
		else $error("exception while disabled");
	apb_answer_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
		else $error("register access not answered");
endmodule

// [l1c_cache_test.sv]
`timescale 1ns/1ps
`include "l1c_map.vh"
module l1c_cache_test;
	reg clk_in = 1'b0;
	reg sys_rst_in = 1'b1;
	reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slv;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0, va = 32'h0, pa = 32'h0, wd = 32'h0, rd;
	reg if_req = 1'b0, ls_req = 1'b0, ls_wr = 1'b0, op_req = 1'b0, prev_rd = 1'b0;
	reg [1:0] op_code = 2'h0;
	reg [3:0] be = 4'hF;
	wire [31:0] prdata, if_data, ls_rdata, mem_addr, mem_rdata, wb_addr, wb_data;
	wire pready, pslverr, if_valid, ls_valid, op_done, mem_rd, mem_rvalid, mem_rpar;
	wire wb_valid, wb_data_par, wb_ready, exc;
	wire [3:0] wb_addr_par;
	integer n_mismatch = 0, compares = 0, cycles = 0, fills = 0, n_exc = 0, f0, n0;
	always #50 clk_in = ~clk_in;
	l1c_cache i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(1'b1),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.if_req_in(if_req), .if_va_in(va), .if_pa_in(pa), .if_valid_out(if_valid),
		.if_data_out(if_data), .ls_req_in(ls_req), .ls_wr_in(ls_wr), .ls_va_in(va),
		.ls_pa_in(pa), .ls_wdata_in(wd), .ls_be_in(be), .ls_valid_out(ls_valid),
		.ls_rdata_out(ls_rdata), .op_req_in(op_req), .op_code_in(op_code), .op_va_in(va),
		.op_pa_in(pa), .op_done_out(op_done), .mem_rd_out(mem_rd), .mem_addr_out(mem_addr),
		.mem_rvalid_in(mem_rvalid), .mem_rdata_in(mem_rdata), .mem_rpar_in(mem_rpar),
		.wb_valid_out(wb_valid), .wb_addr_out(wb_addr), .wb_addr_par_out(wb_addr_par),
		.wb_data_out(wb_data), .wb_data_par_out(wb_data_par), .wb_ready_in(wb_ready),
		.cache_err_exc_out(exc));
	l1c_mem_model i_mem (.clk_in(clk_in), .mem_rd_in(mem_rd), .mem_addr_in(mem_addr),
		.mem_rvalid_out(mem_rvalid), .mem_rdata_out(mem_rdata), .mem_rpar_out(mem_rpar),
		.wb_valid_in(wb_valid), .wb_data_in(wb_data), .wb_ready_out(wb_ready));
	task close_out;
		$display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		prev_rd <= mem_rd;
		if (mem_rd && !prev_rd)
			fills <= fills + 1;
		if (exc)
			n_exc <= n_exc + 1;
		if (cycles == 20000) begin
			n_mismatch = n_mismatch + 1;
			close_out;
		end
	end
	task chk(input [8*14-1:0] what, input [31:0] exp, input [31:0] got);
		compares = compares + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("ERROR %0s expected %h seen %h", what, exp, got);
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		@(posedge clk_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		do @(posedge clk_in); while (pready !== 1'b1);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// k: 0 fetch, 1 load, 2 store; request held until its answer is sampled
	task acc(input [1:0] k, input [31:0] v, input [31:0] p, input [31:0] d);
		@(posedge clk_in);
		va <= v;
		pa <= p;
		wd <= d;
		ls_wr <= (k == 2'h2);
		if_req <= (k == 2'h0);
		ls_req <= (k != 2'h0);
		do @(posedge clk_in); while (k == 2'h0 ? if_valid !== 1'b1 : ls_valid !== 1'b1);
		rd = (k == 2'h0) ? if_data : ls_rdata;
		if_req <= 1'b0;
		ls_req <= 1'b0;
	endtask
	task op(input [1:0] c, input [31:0] v, input [31:0] p);
		@(posedge clk_in);
		va <= v;
		pa <= p;
		op_code <= c;
		op_req <= 1'b1;
		do @(posedge clk_in); while (op_done !== 1'b1);
		op_req <= 1'b0;
	endtask
	initial begin
		repeat (20) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		apb(1'b0, `L1C_APB_CTRL, 32'h0);
		chk("ctrl reset", 32'h1, rd);
		apb(1'b0, 8'h0C, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, slv});
		apb(1'b1, `L1C_APB_CTRL, 32'h0);
		$display("test registers done");
		f0 = fills;
		acc(2'h1, 32'h100, 32'h1100, 32'h0);
		chk("load miss", ~32'h1100, rd);
		acc(2'h1, 32'h10C, 32'h110C, 32'h0);
		chk("line word3", ~32'h110C, rd);
		chk("line fills", f0 + 1, fills);
		acc(2'h2, 32'h104, 32'h1104, 32'h12345678);
		acc(2'h1, 32'h104, 32'h1104, 32'h0);
		chk("store hit", 32'h12345678, rd);
		be <= 4'h1;
		acc(2'h2, 32'h104, 32'h1104, 32'hFFFFFFAA);
		be <= 4'hF;
		acc(2'h1, 32'h104, 32'h1104, 32'h0);
		chk("partial store", 32'h123456AA, rd);
		chk("early wb", 32'h0, i_mem.wbn);
		acc(2'h1, 32'h504, 32'h2104, 32'h0);
		chk("conflict load", ~32'h2104, rd);
		chk("victim words", 32'h4, i_mem.wbn);
		chk("victim word1", 32'h123456AA, i_mem.wbd[1]);
		chk("victim word0", ~32'h1100, i_mem.wbd[0]);
		$display("test replace done");
		i_mem.slow = 1'b1;
		acc(2'h2, 32'h504, 32'h2104, 32'hCAFE0001);
		op(2'h1, 32'h504, 32'h2104);
		chk("op wb words", 32'h8, i_mem.wbn);
		chk("op wb word1", 32'hCAFE0001, i_mem.wbd[5]);
		f0 = fills;
		acc(2'h1, 32'h504, 32'h2104, 32'h0);
		chk("refill", f0 + 1, fills);
		i_mem.slow = 1'b0;
		$display("test writeback op done");
		f0 = fills;
		acc(2'h0, 32'h000, 32'h3000, 32'h0);
		acc(2'h0, 32'h400, 32'h3400, 32'h0);
		acc(2'h0, 32'h000, 32'h3000, 32'h0);
		chk("fetch hit", ~32'h3000, rd);
		chk("fetch fills", f0 + 2, fills);
		$display("test fetch done");
		i_mem.bad = 1'b1;
		n0 = n_exc;
		acc(2'h1, 32'h200, 32'h4200, 32'h0);
		chk("parity exc", n0 + 1, n_exc);
		apb(1'b0, `L1C_APB_ERR, 32'h0);
		chk("err source", 32'h1 << `L1C_ERR_MEM, rd);
		apb(1'b1, `L1C_APB_ERR, 32'hFF);
		apb(1'b0, `L1C_APB_ERR, 32'h0);
		chk("err cleared", 32'h0, rd);
		apb(1'b1, `L1C_APB_CTRL, 32'h1);
		n0 = n_exc;
		acc(2'h1, 32'h300, 32'h4300, 32'h0);
		chk("masked exc", n0, n_exc);
		i_mem.bad = 1'b0;
		$display("test parity done");
		close_out;
	end
endmodule
bind l1c_cache l1c_cache_props i_props (.*);

// [l1c_map.vh]
`ifndef L1C_MAP_VH
`define L1C_MAP_VH
`define L1C_APB_CTRL 8'h00
`define L1C_APB_ERR 8'h04
`define L1C_APB_STAT 8'h08
`define L1C_CTRL_PXD_BIT 0
`define L1C_CTRL_INV_BIT 1
`define L1C_CTRL_RST 2'h3
`define L1C_ERR_IC_TAG 0
`define L1C_ERR_IC_DATA 1
`define L1C_ERR_DC_TAG 2
`define L1C_ERR_DC_DATA 3
`define L1C_ERR_MEM 4
`define L1C_ERR_WB_TAG 5
`define L1C_ERR_WB_DATA 6
`define L1C_ERR_OP_TAG 7
`define L1C_ERR_W 8
`define L1C_IC_SETS 128
`define L1C_DC_SETS 64
`endif

// [l1c_mem_model.sv]
`timescale 1ns/1ps
module l1c_mem_model (
	input wire clk_in,
	input wire mem_rd_in,
	input wire [31:0] mem_addr_in,
	output reg mem_rvalid_out = 1'b0,
	output reg [31:0] mem_rdata_out = 32'h0,
	output reg mem_rpar_out = 1'b0,
	input wire wb_valid_in,
	input wire [31:0] wb_data_in,
	output reg wb_ready_out = 1'b0
);
	reg slow = 1'b0;
	reg bad = 1'b0;
	reg gap = 1'b0;
	reg [1:0] beat = 2'h0;
	integer wbn = 0;
	reg [31:0] wbd [0:15];
	always @(posedge clk_in) begin
		gap <= slow & ~gap;
		mem_rvalid_out <= 1'b0;
		wb_ready_out <= 1'b0;
		// idle data lines toggle so a stale word is never mistaken for a beat
		mem_rdata_out <= ~mem_rdata_out;
		if (mem_rd_in && !mem_rvalid_out && !gap) begin
			mem_rvalid_out <= 1'b1;
			mem_rdata_out <= ~mem_addr_in;
			// corrupt only the last beat so the requested word stays clean
			mem_rpar_out <= ^(~mem_addr_in) ^ (bad && beat == 2'h3);
			beat <= beat + 2'h1;
		end else if (!mem_rd_in) begin
			beat <= 2'h0;
		end
		if (wb_valid_in && !wb_ready_out && !gap)
			wb_ready_out <= 1'b1;
		if (wb_valid_in && wb_ready_out) begin
			wbd[wbn[3:0]] <= wb_data_in;
			wbn <= wbn + 1;
		end
	end
endmodule
